// ===== lcd_cascade_pkg.sv
// package: constants and carriers for the lcd cascade and frame sync logic
// Functional notes
// - respond only when device number matches address
// - pull sync at start of last backplane
// - sample sync line outside own assertion
// - realign frame to first sync assertion seen
// - sync is open drain with pull-up
// - cascade starts synchronized after reset, no commands
// - strap low: internal oscillator driven out clock
// - strap high: timing from clock pin input
// - display disabled stops clock output drive
// - data input and acknowledge on separate lines
package lcd_cascade_pkg;
   localparam int DEV_NUM_W = 3;
   localparam int SEL_BIT_POS = 2;
   localparam int SUB_HIGH_POS = 1;
   localparam int SUB_LOW_POS = 0;
   localparam int BP_MAX = 4;
   localparam int BP_W = 2;
   localparam int TICKS_PER_BP_DEF = 8;
   localparam int TICK_W = 8;
   localparam int OSC_DIV_DEF = 4;
   localparam int OSC_W = 8;
   localparam logic SYNC_ACTIVE = 1'h0;
   localparam logic STRAP_INTERNAL = 1'h0;
   localparam logic [BP_W-1:0] BP_ZERO = 2'h0;
   localparam logic [TICK_W-1:0] TICK_ZERO = 8'h0;
   localparam logic [OSC_W-1:0] OSC_ZERO = 8'h0;

   typedef struct packed {
      logic sync_o;
      logic sync_oe;
   } sync_pin_s;

   typedef struct packed {
      logic clk_o;
      logic clk_oe;
   } clk_pin_s;

   function automatic logic [DEV_NUM_W-1:0] dev_number(input logic sel, input logic hi, input logic lo);
      dev_number = {sel, hi, lo};
   endfunction
endpackage

// ===== lcd_frame_timer.sv
// frame timer on the link clock: backplane phase counter, sync drive and realign
`timescale 1ns/1ps
module lcd_frame_timer
   import lcd_cascade_pkg::*;
#(
   parameter int TICKS_PER_BP = TICKS_PER_BP_DEF
) (
   // link clock and reset (reset already synchronised to this clock)
   input wire logic i_link_clk,
   input wire logic i_link_rstn,
   // configuration, stable levels taken straight from the top's port without a synchroniser
   input wire logic [BP_W-1:0] i_last_bp,
   // sync pin
   input wire logic i_sync_in,
   output logic o_sync_drive,
   // status
   output logic [BP_W-1:0] o_bp_phase,
   output logic o_frame_toggle
);
   logic s1_reg, s2_reg, s2_d_reg;
   logic [BP_W-1:0] bp_reg, bp_next;
   logic [TICK_W-1:0] tick_reg, tick_next;
   logic drive_reg, drive_next;
   logic tog_reg, tog_next;
   logic sync_fall;

   // the second and third stages feed the edge detector, the first stage never does
   always_ff @(posedge i_link_clk) begin
      s1_reg <= i_sync_in;
      s2_reg <= s1_reg;
      s2_d_reg <= s2_reg;
   end

   // a foreign low while we are not driving means another device started its last phase
   assign sync_fall = !drive_reg && (s2_d_reg != SYNC_ACTIVE) && (s2_reg == SYNC_ACTIVE);

   always_comb begin
      bp_next = bp_reg;
      tick_next = tick_reg;
      drive_next = drive_reg;
      tog_next = tog_reg;
      if (sync_fall && bp_reg != i_last_bp) begin
         bp_next = i_last_bp;
         tick_next = TICK_ZERO;
      end else if (tick_reg == TICK_W'(TICKS_PER_BP - 1)) begin
         tick_next = TICK_ZERO;
         if (bp_reg == i_last_bp) begin
            bp_next = BP_ZERO;
            tog_next = !tog_reg;
         end else begin
            bp_next = bp_reg + 2'h1;
         end
      end else begin
         tick_next = tick_reg + 8'h1;
      end
      // assert for the whole last phase, release otherwise
      drive_next = (bp_next == i_last_bp);
   end

   always_ff @(posedge i_link_clk) begin
      if (!i_link_rstn) begin
         bp_reg <= BP_ZERO;
         tick_reg <= TICK_ZERO;
         drive_reg <= 1'h0;
         tog_reg <= 1'h0;
      end else begin
         bp_reg <= bp_next;
         tick_reg <= tick_next;
         drive_reg <= drive_next;
         tog_reg <= tog_next;
      end
   end

   assign o_sync_drive = drive_reg;
   assign o_bp_phase = bp_reg;
   assign o_frame_toggle = tog_reg;
endmodule // lcd_frame_timer

// ===== lcd_driver_cascade_sync.sv
// top: cascade addressing, clock source selection and frame sync pin
`timescale 1ns/1ps
module lcd_driver_cascade_sync
   import lcd_cascade_pkg::*;
#(
   parameter int TICKS_PER_BP = TICKS_PER_BP_DEF,
   parameter int OSC_DIV = OSC_DIV_DEF
) (
   // core clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // link clock from the clock pin (external source)
   input wire logic i_ext_clk,
   // straps and address pins
   input wire logic i_clock_source_strap,
   input wire logic i_subaddr_pin_low,
   input wire logic i_subaddr_pin_high,
   input wire logic i_slave_addr_select_bit,
   // address compare from the bus decoder
   input wire logic [DEV_NUM_W-1:0] i_addr_dev,
   input wire logic i_addr_valid,
   input wire logic i_ack_req,
   output logic o_selected,
   // serial data and separate acknowledge line
   input wire logic i_sda_in,
   output logic o_sda_data,
   output logic o_ack_output_line_o,
   output logic o_ack_output_line_oe,
   // display control
   input wire logic i_display_enable,
   input wire logic [BP_W-1:0] i_last_bp,
   // clock pin
   output logic o_clk_o,
   output logic o_clk_oe,
   // sync pin
   input wire logic i_sync_in,
   output logic o_sync_o,
   output logic o_sync_oe,
   output logic o_sync_pullup_en,
   // status
   output logic [BP_W-1:0] o_bp_phase,
   output logic o_frame_pulse
);
   logic a1_reg, a2_reg, h1_reg, h2_reg, l1_reg, l2_reg, sd1_reg, sd2_reg;
   logic strap_reg, strap_next;
   logic sel_reg, sel_next;
   logic ack_reg, ack_next;
   logic sda_reg, sda_next;
   logic [OSC_W-1:0] osc_cnt_reg, osc_cnt_next;
   logic osc_reg, osc_next;
   logic clkout_reg, clkout_next;
   logic en1_reg, en2_reg;
   logic t1_reg, t2_reg, t3_reg;
   logic pulse_reg, pulse_next;
   logic link_clk;
   logic lr1_reg, lr2_reg;
   logic sync_drive;
   logic frame_tog;
   logic [BP_W-1:0] bp_phase;
   sync_pin_s sync_pin;
   clk_pin_s clk_pin;

   // pin synchronisers
   always_ff @(posedge i_core_clk) begin
      a1_reg <= i_slave_addr_select_bit;
      a2_reg <= a1_reg;
      h1_reg <= i_subaddr_pin_high;
      h2_reg <= h1_reg;
      l1_reg <= i_subaddr_pin_low;
      l2_reg <= l1_reg;
      sd1_reg <= i_sda_in;
      sd2_reg <= sd1_reg;
   end

   always_comb begin
      // strap caught while reset holds, constant afterwards
      strap_next = (!i_rstn) ? i_clock_source_strap : strap_reg;
      sel_next = i_addr_valid && (i_addr_dev == dev_number(a2_reg, h2_reg, l2_reg));
      ack_next = sel_next && i_ack_req;
      sda_next = sd2_reg;
      osc_next = osc_reg;
      osc_cnt_next = osc_cnt_reg + 8'h1;
      if (osc_cnt_reg == OSC_W'(OSC_DIV - 1)) begin
         osc_cnt_next = OSC_ZERO;
         osc_next = !osc_reg;
      end
      clkout_next = (strap_reg == STRAP_INTERNAL) && en2_reg;
      pulse_next = t2_reg ^ t3_reg;
   end

   always_ff @(posedge i_core_clk) begin
      strap_reg <= strap_next;
      if (!i_rstn) begin
         sel_reg <= 1'h0;
         ack_reg <= 1'h0;
         sda_reg <= 1'h1;
         osc_cnt_reg <= OSC_ZERO;
         osc_reg <= 1'h0;
         clkout_reg <= 1'h0;
         en1_reg <= 1'h0;
         en2_reg <= 1'h0;
         t1_reg <= 1'h0;
         t2_reg <= 1'h0;
         t3_reg <= 1'h0;
         pulse_reg <= 1'h0;
      end else begin
         sel_reg <= sel_next;
         ack_reg <= ack_next;
         sda_reg <= sda_next;
         osc_cnt_reg <= osc_cnt_next;
         osc_reg <= osc_next;
         clkout_reg <= clkout_next;
         en1_reg <= i_display_enable;
         en2_reg <= en1_reg;
         t1_reg <= frame_tog;
         t2_reg <= t1_reg;
         t3_reg <= t2_reg;
         pulse_reg <= pulse_next;
      end
   end

   // internal divider or the clock pin; a real part uses a glitch-free clock mux here
   // the divider is held in reset, so the core clock carries the reset into the link domain
   assign link_clk = (strap_reg != STRAP_INTERNAL) ? i_ext_clk : (i_rstn ? osc_reg : i_core_clk);

   // reset release into the link domain
   always_ff @(posedge link_clk) begin
      lr1_reg <= i_rstn;
      lr2_reg <= lr1_reg;
   end

   lcd_frame_timer #(
      .TICKS_PER_BP(TICKS_PER_BP)
   ) u_timer (
      .i_link_clk(link_clk),
      .i_link_rstn(lr2_reg),
      .i_last_bp(i_last_bp),
      .i_sync_in(i_sync_in),
      .o_sync_drive(sync_drive),
      .o_bp_phase(bp_phase),
      .o_frame_toggle(frame_tog)
   );

   // open drain: only ever drive low, pull-up holds the released level
   assign sync_pin.sync_o = SYNC_ACTIVE;
   assign sync_pin.sync_oe = sync_drive && i_rstn;
   assign clk_pin.clk_o = osc_reg;
   assign clk_pin.clk_oe = clkout_reg;

   assign o_sync_o = sync_pin.sync_o;
   assign o_sync_oe = sync_pin.sync_oe;
   assign o_sync_pullup_en = 1'h1;
   assign o_clk_o = clk_pin.clk_o;
   assign o_clk_oe = clk_pin.clk_oe;
   assign o_selected = sel_reg;
   assign o_sda_data = sda_reg;
   // ack line is separate from data, open drain low while acknowledging
   assign o_ack_output_line_o = 1'h0;
   assign o_ack_output_line_oe = ack_reg;
   assign o_bp_phase = bp_phase;
   assign o_frame_pulse = pulse_reg;
endmodule // lcd_driver_cascade_sync

// ===== lcd_cascade_checker_assertions.sv
// checker: port relations of the cascade sync top
`timescale 1ns/1ps
module lcd_cascade_checker
   import lcd_cascade_pkg::*;
#(parameter int TICKS_PER_BP = TICKS_PER_BP_DEF, parameter int OSC_DIV = OSC_DIV_DEF) (
   // clock, reset, inputs and the backplane phase output
   input wire logic i_core_clk, i_rstn, i_clock_source_strap, i_display_enable, i_sync_in,
   input wire logic i_subaddr_pin_low, i_subaddr_pin_high, i_slave_addr_select_bit, i_addr_valid,
   input wire logic [DEV_NUM_W-1:0] i_addr_dev,
   input wire logic [BP_W-1:0] i_last_bp, o_bp_phase,
   // outputs
   input wire logic o_selected, o_ack_output_line_o, o_ack_output_line_oe, o_clk_o, o_clk_oe,
   input wire logic o_sync_o, o_sync_oe, o_sync_pullup_en
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   // pins pass a synchroniser, so only settled pins are judged
   wire logic [DEV_NUM_W-1:0] pins = {i_slave_addr_select_bit, i_subaddr_pin_high, i_subaddr_pin_low};
   property p_sel; $stable(pins)[*4] |=> o_selected == $past(i_addr_valid && i_addr_dev == pins); endproperty
   a_sel: assert property (p_sel) else $error("select off");
   property p_ack; o_ack_output_line_oe |-> !o_ack_output_line_o && (o_selected || $past(o_selected)); endproperty
   a_ack: assert property (p_ack) else $error("ack off");
   property p_sync_ph; o_sync_oe |-> o_bp_phase == i_last_bp; endproperty
   a_sync_ph: assert property (p_sync_ph) else $error("sync phase");
   property p_sync_od; o_sync_oe |-> o_sync_o == SYNC_ACTIVE && o_sync_pullup_en; endproperty
   a_sync_od: assert property (p_sync_od) else $error("sync level");
   property p_realign; $fell(i_sync_in) && !o_sync_oe |-> ##[1:6] o_bp_phase == i_last_bp; endproperty
   a_realign: assert property (p_realign) else $error("no realign");
   property p_clk_src; o_clk_oe |-> i_clock_source_strap == STRAP_INTERNAL; endproperty
   a_clk_src: assert property (p_clk_src) else $error("clock source");
   property p_clk_osc; o_clk_oe |-> ##[1:4] $changed(o_clk_o); endproperty
   a_clk_osc: assert property (p_clk_osc) else $error("clock stuck");
   property p_clk_dis; !i_display_enable [*4] |-> !o_clk_oe; endproperty
   a_clk_dis: assert property (p_clk_dis) else $error("clock driven");
   c_sel: cover property (o_selected && o_ack_output_line_oe);
   c_sync: cover property (o_sync_oe);
   c_clk: cover property ($rose(o_clk_oe));
endmodule // lcd_cascade_checker
bind lcd_driver_cascade_sync lcd_cascade_checker #(.TICKS_PER_BP(TICKS_PER_BP), .OSC_DIV(OSC_DIV)) chk_u (.*);

// ===== lcd_sync_partner.sv
// partner: a second cascaded driver on the shared sync line
`timescale 1ns/1ps
module lcd_sync_partner #(parameter int TICKS = 8) (
   input wire logic i_link_clk,
   input wire logic i_rstn,
   input wire logic [1:0] i_last_bp,
   output logic o_pull
);
   logic [7:0] cnt_reg;
   // runs from the shared external clock, never its own oscillator
   always_ff @(posedge i_link_clk) begin
      if (!i_rstn || cnt_reg == 8'((i_last_bp + 1) * TICKS - 1)) cnt_reg <= 8'h00;
      else cnt_reg <= cnt_reg + 8'h01;
   end
   // same frame as the device but it never follows, so a lagging device must realign
   // only one device's backplanes reach the glass; this model keeps none of its own
   assign o_pull = i_rstn && cnt_reg >= 8'(i_last_bp * TICKS);
endmodule // lcd_sync_partner

// ===== tb_top.sv
// testbench: addressing, clock source and frame sync of the cascade top
`timescale 1ns/1ps
module tb_top;
   import lcd_cascade_pkg::*;
   logic i_core_clk = 1'h0, i_rstn = 1'h0, i_ext_clk = 1'h0, i_clock_source_strap = 1'h0;
   logic i_subaddr_pin_low = 1'h0, i_subaddr_pin_high = 1'h0, i_slave_addr_select_bit = 1'h0;
   logic i_addr_valid = 1'h0, i_ack_req = 1'h0, i_sda_in = 1'h1, i_display_enable = 1'h0;
   logic i_sync_in, p_rstn = 1'h0, pull, prev;
   logic [2:0] i_addr_dev = 3'h0;
   logic [1:0] i_last_bp = 2'h3, o_bp_phase;
   logic o_selected, o_sda_data, o_ack_output_line_o, o_ack_output_line_oe, o_clk_o, o_clk_oe;
   logic o_sync_o, o_sync_oe, o_sync_pullup_en, o_frame_pulse;
   int n_fail = 0, check_count = 0, k;
   initial forever #50 i_core_clk = ~i_core_clk;
   initial forever #32 i_ext_clk = ~i_ext_clk;
   // wired line: low if anyone pulls, else the pull-up
   assign i_sync_in = (o_sync_oe && o_sync_o == SYNC_ACTIVE) || pull ? 1'h0 : 1'h1;
   lcd_driver_cascade_sync #(.TICKS_PER_BP(4), .OSC_DIV(4)) dut_u (.*);
   lcd_sync_partner #(.TICKS(4)) peer_u (.i_link_clk(i_ext_clk), .i_rstn(p_rstn), .i_last_bp(i_last_bp), .o_pull(pull));
   task automatic step(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   function automatic logic exp_sel();
      return i_addr_valid && i_addr_dev == {i_slave_addr_select_bit, i_subaddr_pin_high, i_subaddr_pin_low};
   endfunction
   // strap is caught in reset; internal oscillator needs a longer hold
   task automatic restart(input logic strap, input logic peer, input int n);
      i_rstn = 1'h0;
      p_rstn = 1'h0;
      i_clock_source_strap = strap;
      step(n);
      i_rstn = 1'h1;
      p_rstn = peer;
   endtask
   task automatic wait_oe(input logic v);
      for (k = 0; k < 99 && o_sync_oe !== v; k++) step(1);
   endtask
   task automatic on_peer(input string what);
      for (k = 0; k < 99 && pull !== 1'h0; k++) step(1);
      for (k = 0; k < 99 && pull !== 1'h1; k++) step(1);
      step(3);
      chk(what, i_last_bp, o_bp_phase);
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      k = $urandom(32'hB0BE);
      // static mode holds sync low all frame, so the release checks need two phases or more
      i_last_bp = 2'(1 + $urandom % 3);
      restart(1'h1, 1'h0, 8);
      wait_oe(1'h1);
      chk("drive phase", i_last_bp, o_bp_phase);
      chk("sync low", 3'(SYNC_ACTIVE), i_sync_in);
      wait_oe(1'h0);
      chk("sync released", 3'h1, i_sync_in);
      chk("pull-up", 3'h1, o_sync_pullup_en);
      i_display_enable = 1'h1;
      for (int i = 0; i < 40; i++) begin
         {i_slave_addr_select_bit, i_subaddr_pin_high, i_subaddr_pin_low} = i < 8 ? 3'(i) : 3'($urandom);
         i_addr_dev = i < 8 ? 3'(i) : 3'($urandom);
         {i_addr_valid, i_ack_req, i_sda_in} = 3'($urandom) | (i < 8 ? 3'h4 : 3'h0);
         step(4);
         chk("selected", exp_sel(), o_selected);
         chk("ack enable", exp_sel() & i_ack_req, o_ack_output_line_oe);
         chk("sda copy", i_sda_in, o_sda_data);
         chk("ack level", 3'h0, o_ack_output_line_o);
      end
      chk("clock drive", 3'h0, o_clk_oe);
      // release the peer just after our own sync falls, so the peer leads and we must follow
      wait_oe(1'h0);
      wait_oe(1'h1);
      p_rstn = 1'h1;
      on_peer("realign");
      on_peer("aligned");
      for (k = 0; k < 40 && o_frame_pulse !== 1'h1; k++) step(1);
      chk("frame pulse", 3'h1, o_frame_pulse);
      step(1);
      chk("pulse width", 3'h0, o_frame_pulse);
      restart(1'h1, 1'h1, 8);
      on_peer("reset aligned");
      restart(1'h0, 1'h0, 40);
      step(6);
      chk("clock drive", 3'h1, o_clk_oe);
      prev = o_clk_o;
      k = 0;
      repeat (16) begin
         step(1);
         if (o_clk_o !== prev) k++;
         prev = o_clk_o;
      end
      chk("clock edges", 3'h4, 3'(k));
      i_display_enable = 1'h0;
      step(5);
      chk("clock drive", 3'h0, o_clk_oe);
      results;
   end
   initial begin
      #2000000;
      n_fail++;
      results;
   end
endmodule // tb_top
